//--- src/sph_device.sv
// sensor end: parameter commands, checks and compensated temperature

// Overview of operation
// RULE1: code 60B2 reaches the compensation parameters
// RULE2: output is raw plus slope times raw plus offset
// RULE3: new offset and slope approach with smoothing
// RULE4: word one is offset, signed, default zero
// RULE5: word two is slope, signed, default zero
// RULE6: word three is time constant, default zero
// RULE7: each data word carries a checksum byte
// RULE8: checksum polynomial 31, init FF, msb first
// RULE9: warm start word, zero cold, default zero
// RULE10: warm start value applied at measurement start
// RULE11: voc tuning writes ignored while measuring
// RULE12: any out-of-range voc value drops the write
// RULE13: voc index offset defaults to 100
// RULE14: offset learning hours default to 12
// RULE15: gain learning hours default to 12
// RULE16: freeze duration minutes defaults to 180
// RULE17: initial deviation estimate defaults to 50
// RULE18: index gain factor defaults to 230
// RULE19: idle, not measuring, after reset
// RULE20: reset returns all parameters to defaults
// RULE21: reads return the held values with checksums
// RULE22: bad checksum discards the whole write
module sph_device import sph_pkg::*; #(
  parameter int STEP_CYC = STEP_CYC_DEF
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  sph_link_if.dev LNK,
  input wire logic MEAS_START,
  input wire logic MEAS_STOP,
  input wire logic [15:0] RAW_TEMP,
  output logic [15:0] COMP_TEMP,
  output logic MEASURING,
  output logic [15:0] WARM_LEVEL,
  output logic [MAX_WORDS*16-1:0] VOC_PARAMS
);
  typedef struct packed {
    logic frm_d;
    logic [1:0] cnt;
    logic [15:0] cmd;
    logic [1:0] ph;
    logic [2:0] wi;
    logic [7:0] hi;
    logic [7:0] lo;
    logic bad;
    logic [MAX_WORDS-1:0][15:0] wbuf;
    logic [1:0] rph;
    logic [2:0] rwi;
    logic rvld;
    logic [7:0] rbyte;
    logic [15:0] ofs;
    logic [15:0] slp;
    logic [15:0] tau;
    logic load;
    logic [15:0] warm;
    logic [15:0] warm_act;
    logic [MAX_WORDS-1:0][15:0] voc;
    logic meas;
  } dev_s;

  dev_s s_r;
  dev_s s_nxt;
  logic [MAX_WORDS-1:0] voc_ok;

  // ----------------------------------------------------------------
  // range check of the received tuning words
  // ----------------------------------------------------------------
  for (genvar k = 0; k < MAX_WORDS; k++) begin : g_rng
    assign voc_ok[k] = $signed(s_r.wbuf[k]) >= $signed(VOC_MIN[k]) &&
      $signed(s_r.wbuf[k]) <= $signed(VOC_MAX[k]); // RULE12
  end

  // ----------------------------------------------------------------
  // link decoding, commit and readback
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] nw;
    logic [15:0] rword;
    logic [2:0][15:0] tcv;
    s_nxt = s_r;
    s_nxt.frm_d = LNK.frm;
    s_nxt.rvld = 1'b0;
    s_nxt.load = 1'b0;
    nw = words_of(s_r.cmd);
    tcv = {s_r.tau, s_r.slp, s_r.ofs};
    // readback source, all ones past the end or for unknown codes
    rword = WORD_NONE;
    if (s_r.rwi < nw) begin
      case (s_r.cmd)
        CMD_TCOMP: rword = tcv[s_r.rwi[1:0]]; // RULE21
        CMD_WARM: rword = s_r.warm; // RULE21
        default: rword = s_r.voc[s_r.rwi]; // RULE21
      endcase
    end
    // a new frame clears all byte and word counters
    if (LNK.frm && !s_r.frm_d) begin
      s_nxt.cnt = '0;
      s_nxt.ph = PH_HI;
      s_nxt.wi = '0;
      s_nxt.bad = 1'b0;
      s_nxt.rph = PH_HI;
      s_nxt.rwi = '0;
    end else if (LNK.frm && LNK.wr_vld) begin
      if (s_r.cnt != CMD_BYTES) begin
        s_nxt.cmd = {s_r.cmd[7:0], LNK.wr_byte};
        s_nxt.cnt = s_r.cnt + 2'h1;
      end else begin
        case (s_r.ph)
          PH_HI: begin
            s_nxt.hi = LNK.wr_byte;
            s_nxt.ph = PH_LO;
          end
          PH_LO: begin
            s_nxt.lo = LNK.wr_byte;
            s_nxt.ph = PH_CRC;
          end
          default: begin
            s_nxt.ph = PH_HI;
            if (crc8({s_r.hi, s_r.lo}) != LNK.wr_byte) begin
              s_nxt.bad = 1'b1; // RULE7 RULE8 RULE22
            end
            // words beyond the longest payload spoil the frame
            if (s_r.wi == CNT_VOC) begin
              s_nxt.bad = 1'b1;
            end else begin
              s_nxt.wbuf[s_r.wi] = {s_r.hi, s_r.lo};
              s_nxt.wi = s_r.wi + 3'h1;
            end
          end
        endcase
      end
    end
    // one byte answered per request, in the cycle after it
    if (LNK.frm && LNK.rd_req && s_r.cnt == CMD_BYTES) begin
      s_nxt.rvld = 1'b1;
      case (s_r.rph)
        PH_HI: begin
          s_nxt.rbyte = rword[15:8];
          s_nxt.rph = PH_LO;
        end
        PH_LO: begin
          s_nxt.rbyte = rword[7:0];
          s_nxt.rph = PH_CRC;
        end
        default: begin
          s_nxt.rbyte = crc8(rword); // RULE7 RULE8 RULE21
          s_nxt.rph = PH_HI;
          if (s_r.rwi != CNT_VOC) s_nxt.rwi = s_r.rwi + 3'h1;
        end
      endcase
    end
    // commit only at frame end, only whole and clean payloads
    if (!LNK.frm && s_r.frm_d && s_r.wi != CNT_NONE && s_r.wi == nw &&
        s_r.ph == PH_HI && !s_r.bad) begin // RULE22
      case (s_r.cmd)
        CMD_TCOMP: begin // RULE1
          s_nxt.ofs = s_r.wbuf[0]; // RULE4
          s_nxt.slp = s_r.wbuf[1]; // RULE5
          s_nxt.tau = s_r.wbuf[2]; // RULE6
          s_nxt.load = 1'b1;
        end
        CMD_WARM: s_nxt.warm = s_r.wbuf[0]; // RULE9 RULE10
        default: begin
          if (!s_r.meas && &voc_ok) s_nxt.voc = s_r.wbuf; // RULE11 RULE12
        end
      endcase
    end
    // start wins over stop; warm start value taken at start
    if (MEAS_START) begin
      s_nxt.meas = 1'b1;
      s_nxt.warm_act = s_r.warm; // RULE10
    end else if (MEAS_STOP) begin
      s_nxt.meas = 1'b0;
    end
  end

  // state register with volatile defaults
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= '0; // RULE19 RULE20
      s_r.ofs <= TOFS_DEF; // RULE4
      s_r.slp <= TSLOPE_DEF; // RULE5
      s_r.tau <= TTAU_DEF; // RULE6
      s_r.warm <= WARM_DEF; // RULE9
      s_r.warm_act <= WARM_DEF;
      s_r.voc <= VOC_DEF; // RULE13 RULE14 RULE15 RULE16 RULE17 RULE18
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // compensation path
  // ----------------------------------------------------------------
  tcomp_smoother #(
    .STEP_CYC(STEP_CYC)
  ) u_smooth (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .load(s_r.load),
    .tgt_ofs(s_r.ofs),
    .tgt_slp(s_r.slp),
    .tau(s_r.tau),
    .raw_temp(RAW_TEMP),
    .comp_temp(COMP_TEMP)
  );

  assign MEASURING = s_r.meas;
  assign WARM_LEVEL = s_r.warm_act;
  assign VOC_PARAMS = s_r.voc;
  assign LNK.rd_vld = s_r.rvld;
  assign LNK.rd_byte = s_r.rbyte;
endmodule

//--- src/sph_host.sv
// host end: wishbone registers drive parameter transfers on the link
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
module sph_host import sph_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic ACK_O,
  output logic [31:0] DAT_O,
  sph_link_if.host LNK
);
  typedef enum {H_IDLE, H_CMD, H_DATA, H_RREQ, H_RWAIT, H_END} hst_e;

  typedef struct packed {
    hst_e st;
    logic frm;
    logic wvld;
    logic [7:0] wbyte;
    logic rreq;
    logic first;
    logic [1:0] ph;
    logic [2:0] wi;
    logic [2:0] nw;
    logic [15:0] cmd;
    logic [1:0] sel;
    logic wr;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [MAX_WORDS-1:0][15:0] words;
    logic busy;
    logic done;
    logic crcerr;
    logic ack;
    logic [31:0] dat;
  } host_s;

  host_s s_r;
  host_s s_nxt;

  always_comb begin
    logic acc;
    logic go;
    logic wsel;
    logic [2:0] widx;
    logic [31:0] rd;
    logic [15:0] w;
    s_nxt = s_r;
    s_nxt.wvld = 1'b0;
    s_nxt.rreq = 1'b0;
    go = 1'b0;
    // classic single-cycle slave: ack one cycle after the strobe
    acc = CYC_I && STB_I && !s_r.ack;
    wsel = ADR_I >= REG_WORD0 && ADR_I <= REG_WORD5 && ADR_I[1:0] == 2'h0;
    widx = 3'((ADR_I - REG_WORD0) >> 2);
    rd = '0;
    if (ADR_I == REG_CTRL) begin
      rd[CTRL_WR] = s_r.wr;
      rd[CTRL_SEL+:2] = s_r.sel;
    end else if (ADR_I == REG_STAT) begin
      rd[ST_BUSY] = s_r.busy;
      rd[ST_DONE] = s_r.done;
      rd[ST_CRCERR] = s_r.crcerr;
    end else if (wsel) begin
      rd[15:0] = s_r.words[widx];
    end
    s_nxt.ack = acc;
    s_nxt.dat = acc ? rd : '0;
    // writes are dropped while a transfer runs
    if (acc && WE_I && !s_r.busy) begin
      if (ADR_I == REG_CTRL && SEL_I[0]) begin
        s_nxt.wr = DAT_I[CTRL_WR];
        s_nxt.sel = DAT_I[CTRL_SEL+:2];
        go = DAT_I[CTRL_GO];
      end else if (wsel) begin
        if (SEL_I[0]) s_nxt.words[widx][7:0] = DAT_I[7:0];
        if (SEL_I[1]) s_nxt.words[widx][15:8] = DAT_I[15:8];
      end
    end
    w = s_r.words[s_r.wi];
    case (s_r.st)
      H_IDLE: begin
        if (go) begin
          s_nxt.cmd = (DAT_I[CTRL_SEL+:2] == SEL_TCOMP) ? CMD_TCOMP : // RULE1
            (DAT_I[CTRL_SEL+:2] == SEL_WARM) ? CMD_WARM : CMD_VOC;
          s_nxt.nw = words_of(s_nxt.cmd);
          s_nxt.frm = 1'b1;
          s_nxt.first = 1'b0;
          s_nxt.ph = PH_HI;
          s_nxt.wi = '0;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
          s_nxt.crcerr = 1'b0;
          s_nxt.st = H_CMD;
        end
      end
      H_CMD: begin
        s_nxt.wvld = 1'b1;
        s_nxt.wbyte = s_r.first ? s_r.cmd[7:0] : s_r.cmd[15:8];
        s_nxt.first = 1'b1;
        if (s_r.first) s_nxt.st = s_r.wr ? H_DATA : H_RREQ;
      end
      H_DATA: begin
        s_nxt.wvld = 1'b1;
        case (s_r.ph)
          PH_HI: begin
            s_nxt.wbyte = w[15:8];
            s_nxt.ph = PH_LO;
          end
          PH_LO: begin
            s_nxt.wbyte = w[7:0];
            s_nxt.ph = PH_CRC;
          end
          default: begin
            s_nxt.wbyte = crc8(w); // RULE7 RULE8
            s_nxt.ph = PH_HI;
            s_nxt.wi = s_r.wi + 3'h1;
            if (s_r.wi + 3'h1 == s_r.nw) s_nxt.st = H_END;
          end
        endcase
      end
      H_RREQ: begin
        s_nxt.rreq = 1'b1;
        s_nxt.st = H_RWAIT;
      end
      H_RWAIT: begin
        if (LNK.rd_vld) begin
          s_nxt.st = H_RREQ;
          case (s_r.ph)
            PH_HI: begin
              s_nxt.hi = LNK.rd_byte;
              s_nxt.ph = PH_LO;
            end
            PH_LO: begin
              s_nxt.lo = LNK.rd_byte;
              s_nxt.ph = PH_CRC;
            end
            default: begin
              s_nxt.words[s_r.wi] = {s_r.hi, s_r.lo};
              if (crc8({s_r.hi, s_r.lo}) != LNK.rd_byte) begin
                s_nxt.crcerr = 1'b1; // RULE7
              end
              s_nxt.ph = PH_HI;
              s_nxt.wi = s_r.wi + 3'h1;
              if (s_r.wi + 3'h1 == s_r.nw) s_nxt.st = H_END;
            end
          endcase
        end
      end
      H_END: begin
        s_nxt.frm = 1'b0;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = H_IDLE;
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  // state register, payload words start at zero
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.st <= H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ACK_O = s_r.ack;
  assign DAT_O = s_r.dat;
  assign LNK.frm = s_r.frm;
  assign LNK.wr_vld = s_r.wvld;
  assign LNK.wr_byte = s_r.wbyte;
  assign LNK.rd_req = s_r.rreq;
endmodule

//--- src/sph_link_if.sv
// byte link between the parameter host and the sensor end
interface sph_link_if;
  logic frm;
  logic wr_vld;
  logic [7:0] wr_byte;
  logic rd_req;
  logic rd_vld;
  logic [7:0] rd_byte;
  modport host(output frm, output wr_vld, output wr_byte, output rd_req,
    input rd_vld, input rd_byte);
  modport dev(input frm, input wr_vld, input wr_byte, input rd_req,
    output rd_vld, output rd_byte);
endinterface

//--- src/sph_pkg.sv
// shared constants and the checksum function for both ends
package sph_pkg;

  // ----------------------------------------------------------------
  // command codes and payload layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_TCOMP = 16'h60B2;
  localparam logic [15:0] CMD_WARM = 16'h60C6;
  localparam logic [15:0] CMD_VOC = 16'h60D0;
  localparam logic [1:0] CMD_BYTES = 2'h2;
  localparam int MAX_WORDS = 6;
  localparam logic [2:0] CNT_NONE = 3'h0;
  localparam logic [2:0] CNT_TC = 3'h3;
  localparam logic [2:0] CNT_WARM = 3'h1;
  localparam logic [2:0] CNT_VOC = 3'h6;
  localparam logic [1:0] PH_HI = 2'h0;
  localparam logic [1:0] PH_LO = 2'h1;
  localparam logic [1:0] PH_CRC = 2'h2;
  localparam logic [15:0] WORD_NONE = 16'hFFFF;

  // ----------------------------------------------------------------
  // checksum
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // ----------------------------------------------------------------
  // parameter defaults and ranges, word 0 in the low slot
  // ----------------------------------------------------------------
  localparam logic [15:0] TOFS_DEF = 16'h0000;
  localparam logic [15:0] TSLOPE_DEF = 16'h0000;
  localparam logic [15:0] TTAU_DEF = 16'h0000;
  localparam logic [15:0] WARM_DEF = 16'h0000;
  localparam logic [15:0] WARM_FULL = 16'hFFFF;
  localparam logic [MAX_WORDS-1:0][15:0] VOC_DEF = {16'h00E6, 16'h0032,
    16'h00B4, 16'h000C, 16'h000C, 16'h0064};
  localparam logic [MAX_WORDS-1:0][15:0] VOC_MIN = {16'h0001, 16'h000A,
    16'h0000, 16'h0001, 16'h0001, 16'h0001};
  localparam logic [MAX_WORDS-1:0][15:0] VOC_MAX = {16'h03E8, 16'h1388,
    16'h0BB8, 16'h03E8, 16'h03E8, 16'h00FA};

  // ----------------------------------------------------------------
  // timing of the compensation smoothing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int SEC_NS = 1000000000;
  localparam int SMOOTH_SHIFT = 6;
  localparam int STEP_CYC_DEF = (SEC_NS / CLK_NS) >> SMOOTH_SHIFT;
  localparam int SLOPE_SCALE = 10000;

  // ----------------------------------------------------------------
  // host register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WORD0 = 8'h08;
  localparam logic [7:0] REG_WORD5 = 8'h1C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_SEL = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CRCERR = 2;
  localparam logic [1:0] SEL_TCOMP = 2'h0;
  localparam logic [1:0] SEL_WARM = 2'h1;

  // msb-first crc over one data word, no reflection, no final xor
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : '0);
    end
    return c;
  endfunction

  // data words carried by each command, zero for unknown codes
  function automatic logic [2:0] words_of(input logic [15:0] c);
    case (c)
      CMD_TCOMP: return CNT_TC;
      CMD_WARM: return CNT_WARM;
      CMD_VOC: return CNT_VOC;
      default: return CNT_NONE;
    endcase
  endfunction

endpackage

//--- src/tcomp_smoother.sv
// first-order smoothing of offset and slope, compensated temperature
module tcomp_smoother import sph_pkg::*; #(
  parameter int STEP_CYC = STEP_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] tgt_ofs,
  input wire logic [15:0] tgt_slp,
  input wire logic [15:0] tau,
  input wire logic [15:0] raw_temp,
  output logic [15:0] comp_temp
);
  localparam int FW = 16 + SMOOTH_SHIFT + 2;
  localparam int TW = 40;

  typedef struct packed {
    logic signed [FW-1:0] ofs_f;
    logic signed [FW-1:0] slp_f;
    logic [TW-1:0] tmr;
    logic [15:0] comp;
  } sm_s;

  sm_s s_r;
  sm_s s_nxt;

  // 64 steps of 1/64 each over one time constant leave 36.5 % behind
  always_comb begin
    logic signed [FW-1:0] tofs;
    logic signed [FW-1:0] tslp;
    logic signed [15:0] ofs_i;
    logic signed [15:0] slp_i;
    logic signed [31:0] prod;
    logic signed [31:0] sum;
    logic [TW-1:0] lim;
    tofs = FW'($signed(tgt_ofs)) <<< SMOOTH_SHIFT;
    tslp = FW'($signed(tgt_slp)) <<< SMOOTH_SHIFT;
    lim = TW'(tau) * TW'(STEP_CYC);
    s_nxt = s_r;
    if (load || tau == '0) begin
      s_nxt.tmr = '0;
    end else if (s_r.tmr >= lim - TW'(1)) begin
      s_nxt.tmr = '0;
      s_nxt.ofs_f = s_r.ofs_f + ((tofs - s_r.ofs_f) >>> SMOOTH_SHIFT); // RULE3
      s_nxt.slp_f = s_r.slp_f + ((tslp - s_r.slp_f) >>> SMOOTH_SHIFT); // RULE3
    end else begin
      s_nxt.tmr = s_r.tmr + TW'(1);
    end
    // zero time constant means the new values apply at once
    if (tau == '0) begin
      s_nxt.ofs_f = tofs;
      s_nxt.slp_f = tslp;
    end
    ofs_i = 16'(s_r.ofs_f >>> SMOOTH_SHIFT);
    slp_i = 16'(s_r.slp_f >>> SMOOTH_SHIFT);
    prod = 32'($signed(raw_temp)) * 32'(slp_i);
    // result wraps at 16 bits, no saturation
    sum = 32'($signed(raw_temp)) + prod / SLOPE_SCALE + 32'(ofs_i); // RULE2
    s_nxt.comp = 16'(sum);
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign comp_temp = s_r.comp;
endmodule

//--- verif/sph_link_props.sv
// checks on the parameter byte link
module sph_link_props (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic frm,
  input wire logic wr_vld,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic rd_vld,
  input wire logic [7:0] rd_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] cnt;
    logic [1:0] pos;
    logic [15:0] word;
  } trk_s;
  trk_s t_r;
  trk_s t_nxt;
  logic bv;
  logic [7:0] bb;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ----------------------------------
  // own reference checksum
  // ----------------------------------
  function automatic logic [7:0] crc_of(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction

  // byte tracker, count saturates
  assign bv = frm && (wr_vld || rd_vld);
  assign bb = wr_vld ? wr_byte : rd_byte;
  always_comb begin
    t_nxt = t_r;
    if (!frm) begin
      t_nxt.cnt = 5'h00;
      t_nxt.pos = 2'h0;
    end else if (bv) begin
      if (t_r.cnt != 5'h1F) begin
        t_nxt.cnt = t_r.cnt + 5'h01;
      end
      if (t_r.cnt >= 5'h02) begin
        t_nxt.pos = (t_r.pos == 2'h2) ? 2'h0 : t_r.pos + 2'h1;
        if (t_r.pos == 2'h0) t_nxt.word[15:8] = bb;
        if (t_r.pos == 2'h1) t_nxt.word[7:0] = bb;
      end
    end
  end

  // tracker register
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  // ----------------------------------
  // link properties
  // ----------------------------------
  chk_answer_next: assert property (rd_req |=> rd_vld)
    else $error("read not answered");
  chk_answer_cause: assert property (rd_vld |-> $past(rd_req))
    else $error("unrequested read byte");
  chk_byte_framed: assert property (wr_vld |-> frm)
    else $error("write byte outside a frame");
  chk_req_framed: assert property (rd_req |-> frm)
    else $error("read request outside a frame");
  chk_req_single: assert property (rd_req |=> !rd_req)
    else $error("read requests back to back");
  chk_frame_lead: assert property ($rose(frm) |-> !wr_vld && !rd_req)
    else $error("traffic in the first frame cycle");
  chk_cmd_high: assert property
    (wr_vld && t_r.cnt == 5'h00 |-> wr_byte == 8'h60)
    else $error("wrong first command byte");
  chk_cmd_low: assert property
    (wr_vld && t_r.cnt == 5'h01 |-> wr_byte inside {8'hB2, 8'hC6, 8'hD0})
    else $error("wrong second command byte");
  chk_wr_crc: assert property
    (bv && wr_vld && t_r.cnt >= 5'h02 && t_r.pos == 2'h2
      |-> wr_byte == crc_of(t_r.word))
    else $error("bad write checksum");
  chk_rd_crc: assert property
    (bv && rd_vld && t_r.pos == 2'h2 |-> rd_byte == crc_of(t_r.word))
    else $error("bad read checksum");
endmodule

//--- verif/test_sensor_param_command_handler.sv
// bench: host and sensor ends on one link
module test_sensor_param_command_handler import sph_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [95:0] dflt_voc = {16'd230, 16'd50, 16'd180, 16'd12,
    16'd12, 16'd100};
  localparam logic [95:0] hi_voc = {16'd1000, 16'd5000, 16'd3000, 16'd1000,
    16'd1000, 16'd250};
  localparam logic [95:0] lo_voc = {16'd1, 16'd10, 16'd0, 16'd1, 16'd1,
    16'd1};
  localparam logic [95:0] bad_voc = {16'd0, 16'd9, 16'd3001, 16'd1001,
    16'd0, 16'd251};
  logic clk, rst, cyc, stb, we, ack, start, stop, start2, meas;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dati, dato;
  logic [15:0] raw, comp, warm, warm2;
  logic [95:0] voc, v;
  int bad_count, checked;
  sph_link_if lnk();
  sph_link_if lnk2();

  // ----------------------------------
  // design, spare sensor end, checker
  // ----------------------------------
  sph_host sph_host_i (.CORE_CLK(clk), .SYS_RST(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dati),
    .ACK_O(ack), .DAT_O(dato), .LNK(lnk.host));
  sph_device #(.STEP_CYC(4)) sph_device_i (.CORE_CLK(clk), .SYS_RST(rst),
    .LNK(lnk.dev), .MEAS_START(start), .MEAS_STOP(stop), .RAW_TEMP(raw),
    .COMP_TEMP(comp), .MEASURING(meas), .WARM_LEVEL(warm),
    .VOC_PARAMS(voc));
  sph_device #(.STEP_CYC(4)) sph_device_i2 (.CORE_CLK(clk), .SYS_RST(rst),
    .LNK(lnk2.dev), .MEAS_START(start2), .MEAS_STOP(1'b0),
    .RAW_TEMP(16'h0000), .COMP_TEMP(), .MEASURING(), .WARM_LEVEL(warm2),
    .VOC_PARAMS());
  sph_link_props sph_link_props_i (.CORE_CLK(clk), .SYS_RST(rst),
    .frm(lnk.frm), .wr_vld(lnk.wr_vld), .wr_byte(lnk.wr_byte),
    .rd_req(lnk.rd_req), .rd_vld(lnk.rd_vld), .rd_byte(lnk.rd_byte));

  // 125 MHz core clock
  always #4 clk = ~clk;

  // ----------------------------------
  // shared tasks
  // ----------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [95:0] exp,
      input logic [95:0] got);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  // classic single cycle, bounded wait
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dati, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      report_and_stop;
    end
    q = dato;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic put(input logic [95:0] w6);
    logic [31:0] q;
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, REG_WORD0 + 8'(4 * k), {16'h0000, w6[16*k +: 16]}, q);
    end
  endtask
  task automatic get(output logic [95:0] w6);
    logic [31:0] q;
    for (int k = 0; k < 6; k++) begin
      wb(1'b0, REG_WORD0 + 8'(4 * k), 32'h0, q);
      w6[16*k +: 16] = q[15:0];
    end
  endtask
  // one link transfer, polled to done
  task automatic xfer(input logic [1:0] s, input logic w);
    logic [31:0] q;
    int n;
    wb(1'b1, REG_CTRL, {28'h0, s, w, 1'b1}, q);
    n = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0, q);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 100);
    chk("transfer status", 96'h2, {93'h0, q[2:0]});
  endtask
  task automatic lbyte(input logic [7:0] b);
    @(posedge clk);
    {lnk2.wr_vld, lnk2.wr_byte} <= {1'b1, b};
    @(posedge clk);
    lnk2.wr_vld <= 1'b0;
  endtask
  // warm write on the spare link, given crc
  task automatic lframe(input logic [7:0] c);
    @(posedge clk);
    lnk2.frm <= 1'b1;
    lbyte(8'h60);
    lbyte(8'hC6);
    lbyte(8'hBE);
    lbyte(8'hEF);
    lbyte(c);
    lnk2.frm <= 1'b0;
    @(posedge clk);
    start2 <= 1'b1;
    @(posedge clk);
    start2 <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------
  // scenarios
  // ----------------------------------
  task automatic t_defaults;
    logic [31:0] q;
    raw <= 16'd2000;
    repeat (3) @(posedge clk);
    chk("measuring", 96'h0, {95'h0, meas});
    chk("warm level", 96'h0, {80'h0, warm});
    chk("voc defaults", dflt_voc, voc);
    chk("plain temp", 96'd2000, {80'h0, comp});
    wb(1'b1, 8'hF0, 32'h0000FFFF, q);
    wb(1'b0, 8'hF0, 32'h0, q);
    chk("unmapped read", 96'h0, {64'h0, q});
    put({96{1'b1}});
    xfer(SEL_TCOMP, 1'b0);
    get(v);
    chk("tcomp defaults", 96'h0, {48'h0, v[47:0]});
  endtask
  task automatic t_tcomp;
    put({48'h0, 16'h0000, 16'd1000, 16'd200});
    xfer(SEL_TCOMP, 1'b1);
    repeat (3) @(posedge clk);
    chk("comp temp", 96'd2400, {80'h0, comp});
    raw <= 16'hF830;
    repeat (3) @(posedge clk);
    chk("comp negative", 96'hF830, {80'h0, comp});
    put({96{1'b1}});
    xfer(SEL_TCOMP, 1'b0);
    get(v);
    chk("tcomp readback", {64'h0, 16'd1000, 16'd200}, {48'h0, v[47:0]});
    // tau 1 s: 64 steps of 4 cycles
    raw <= 16'h0000;
    put({48'h0, 16'd1, 16'd0, 16'd6600});
    xfer(SEL_TCOMP, 1'b1);
    chk("smooth early", 96'h1, {95'h0, $signed(comp) < 16'sd1000});
    repeat (250) @(posedge clk);
    chk("smooth at tau", 96'h1, {95'h0, $signed(comp) > 16'sd3900 &&
      $signed(comp) < 16'sd4600});
  endtask
  task automatic t_warm_voc;
    put({80'h0, 16'hFFFF});
    xfer(SEL_WARM, 1'b1);
    chk("warm before start", 96'h0, {80'h0, warm});
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    chk("measuring", 96'h1, {95'h0, meas});
    chk("warm applied", 96'hFFFF, {80'h0, warm});
    put(hi_voc);
    xfer(2'h2, 1'b1);
    chk("voc while measuring", dflt_voc, voc);
    put(96'h0);
    xfer(SEL_WARM, 1'b0);
    get(v);
    chk("warm readback", 96'hFFFF, {80'h0, v[15:0]});
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (2) @(posedge clk);
    chk("idle again", 96'h0, {95'h0, meas});
    for (int k = 0; k < 6; k++) begin
      v = hi_voc;
      v[16*k +: 16] = bad_voc[16*k +: 16];
      put(v);
      xfer(2'h3, 1'b1);
      chk("voc out of range", dflt_voc, voc);
    end
    put(lo_voc);
    xfer(2'h3, 1'b1);
    chk("voc low limits", lo_voc, voc);
    put(hi_voc);
    xfer(2'h2, 1'b1);
    chk("voc high limits", hi_voc, voc);
    put(96'h0);
    xfer(2'h2, 1'b0);
    get(v);
    chk("voc readback", hi_voc, v);
  endtask
  task automatic t_link_faults;
    lframe(8'h93);
    chk("bad crc dropped", 96'h0, {80'h0, warm2});
    lframe(8'h92);
    chk("good crc taken", 96'hBEEF, {80'h0, warm2});
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("voc after reset", dflt_voc, voc);
    chk("warm after reset", 96'h0, {64'h0, warm, warm2});
  endtask

  // main sequence
  initial begin
    {clk, rst, cyc, stb, we, start, stop, start2} = 8'h40;
    {adr, sel, dati, raw} = '0;
    {lnk2.frm, lnk2.wr_vld, lnk2.wr_byte, lnk2.rd_req} = '0;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_tcomp;
    t_warm_voc;
    t_link_faults;
    report_and_stop;
  end

  // watchdog, far past the run's length
  initial begin
    #320000;
    bad_count++;
    report_and_stop;
  end
endmodule
